// File: rtl/fpmc_defs.vh
`ifndef FPMC_DEFS_VH
`define FPMC_DEFS_VH
// ==========================================================
// Operation codes presented by the sequencer
`define FPMC_OP_W 4
`define FPMC_OP_LD_S 4'h0
`define FPMC_OP_ST_S 4'h1
`define FPMC_OP_RR_S 4'h2
`define FPMC_OP_LD_D 4'h3
`define FPMC_OP_ST_D 4'h4
`define FPMC_OP_RR_D 4'h5
`define FPMC_OP_CVL_S 4'h6
`define FPMC_OP_CVS_S 4'h7
`define FPMC_OP_CVL_L 4'h8
`define FPMC_OP_CVS_L 4'h9
// ==========================================================
// Floating-point format: sign, 7-bit excess-64 characteristic, fraction
`define FPMC_SIGN 63
`define FPMC_CHAR_HI 62
`define FPMC_CHAR_LO 56
`define FPMC_FRAC_HI 55
`define FPMC_BIAS 7'h40
`define FPMC_CHAR_INT 7'h48
`define FPMC_LEVELS 4
`define FPMC_REGS 8
// ==========================================================
// Exception codes
`define FPMC_EXC_NONE 3'h0
`define FPMC_EXC_ADDR 3'h1
`define FPMC_EXC_PROT 3'h2
`define FPMC_EXC_SPEC 3'h3
`define FPMC_EXC_FUNC 3'h4
// ==========================================================
// Conversion limits in hex digits
`define FPMC_DIG_S 6'h04
`define FPMC_DIG_L 6'h08
`endif

// File: rtl/fpmc_unit.v
// Summary of operation
// - Single load reads 32-bit storage word into register
// - Register chosen by field and interrupt level
// - Single load zeros lower register half
// - Single store writes upper half, register kept
// - Single move copies upper half, zeros lower
// - Short convert-load: 16-bit integer to normalized float
// - Long convert-load: 32-bit integer to normalized float
// - Short convert-store: upper half to truncated 16-bit
// - Long convert-store: full register to truncated 32-bit
// - Negative characteristic stores integer zero
// - Short convert-store overflow outside 16-bit range
// - Long convert-store overflow outside 32-bit range
// - Double load reads 64-bit storage into register
// - Moves, convert-loads reset O,E,C; set N,Z
// - Convert-stores reset E,C; set N,Z
// - Address beyond storage raises invalid-address check
// - Problem-state unassigned access raises protect check
// - Problem-state write to read-only raises protect
// - Odd address raises specification check
// - Missing option raises invalid-function trap, terminates
// - Register forms without option are suppressed
`timescale 1ns/1ps
`default_nettype none
`include "fpmc_defs.vh"

module fpmc_unit (
  // Clock, reset, enable
  input wire core_clk,
  input wire rst_n,
  input wire clk_en,
  // Sequencer request
  input wire req_valid,
  input wire [3:0] op_code,
  input wire [2:0] source_reg_field,
  input wire [2:0] dest_reg_field,
  input wire [1:0] cur_level,
  input wire [15:0] storage_operand_address,
  input wire [63:0] load_data,
  // Storage and state qualifiers
  input wire addr_out_of_range,
  input wire problem_state,
  input wire area_unassigned,
  input wire area_read_only,
  input wire fp_option_present,
  // Storage write
  output reg store_valid,
  output reg [15:0] store_addr,
  output reg [63:0] store_data,
  output reg [1:0] store_size,
  // Completion, indicators, exceptions
  output reg done,
  output reg ind_overflow,
  output reg ind_even,
  output reg ind_carry,
  output reg ind_negative,
  output reg ind_zero,
  output reg [2:0] exc_code,
  output reg exc_suppress
);

  // ========================================================
  // Register banks, one per interrupt level
  // Each level owns eight 64-bit registers; the bank index is the level
  // on top of the register field, so a level switch needs no copying.
  // Single-precision values live in the upper half of a register; the
  // lower half is cleared whenever a single value is written.
  reg [63:0] fpr_q [0:`FPMC_LEVELS*`FPMC_REGS-1];

  // Bank index from level and register field
  function [4:0] fpmc_idx;
    input [1:0] lvl;
    input [2:0] fld;
    begin
      fpmc_idx = {lvl, fld};
    end
  endfunction

  // Normalize a signed integer (magnitude up to 32 bits) to hex float
  // The magnitude starts as an eight-digit fraction with characteristic
  // eight above the bias; each leading zero digit shifts out one place.
  // Seven shifts suffice for any nonzero input, the eighth never fires.
  // A zero magnitude gives true zero, so no minus zero ever appears.
  function [63:0] fpmc_norm;
    input [31:0] mag;
    input sgn;
    reg [55:0] f;
    reg [6:0] c;
    integer k;
    begin
      f = {mag, 24'h000000};
      c = `FPMC_CHAR_INT;
      for (k = 0; k < 8; k = k + 1)
      begin
        if (f != 56'h0 && f[55:52] == 4'h0)
        begin
          f = {f[51:0], 4'h0}; // Zeros enter at the low end
          c = c - 7'h01;
        end
      end
      if (f == 56'h0)
        fpmc_norm = 64'h0; // True zero
      else
        fpmc_norm = {sgn, c, f};
    end
  endfunction

  // Convert float to truncated integer; ovf flags out-of-range
  // The exponent in hex digits says how many fraction digits move into
  // the integer part; digits left behind are the truncated fraction.
  // An exponent above the digit limit cannot fit and skips the shift,
  // which keeps the shifter small at the cost of storing zero then.
  // The sign is applied last, so minus the limit still fits exactly.
  function [33:0] fpmc_toint;
    input [63:0] v;
    input [5:0] lim;
    reg [6:0] c;
    reg [87:0] sh;
    reg [32:0] m;
    reg [32:0] r;
    reg ovf;
    integer k;
    begin
      c = v[`FPMC_CHAR_HI:`FPMC_CHAR_LO];
      sh = {32'h0, v[`FPMC_FRAC_HI:0]};
      ovf = 1'b0;
      m = 33'h0;
      if (c >= `FPMC_BIAS)
      begin
        if ((c - `FPMC_BIAS) > {1'b0, lim})
          ovf = 1'b1;
        else
        begin
          for (k = 0; k < 8; k = k + 1)
            if (k < (c - `FPMC_BIAS))
              sh = {sh[83:0], 4'h0};
          m = {1'b0, sh[87:56]}; // Fraction truncated
        end
      end
      r = v[`FPMC_SIGN] ? (33'h0 - m) : m;
      if (lim == `FPMC_DIG_S)
        ovf = ovf | (v[`FPMC_SIGN] ? (m > 33'h8000) : (m > 33'h7fff));
      else
        ovf = ovf | (v[`FPMC_SIGN] ? (m > 33'h80000000) : (m > 33'h7fffffff));
      fpmc_toint = {ovf, r};
    end
  endfunction

  // ========================================================
  // Decode and operand selection
  reg [63:0] src_v;
  reg [63:0] res_v;
  reg [33:0] cv;
  // Operation class flags
  reg is_rr;
  reg is_store;
  reg is_cvs;
  reg wr_reg;
  reg [2:0] exc_d;
  reg [4:0] dst_i;

  // All decode is combinational from the request so that the result
  // registers one edge after the request is taken, with no wait state.
  // The long convert is computed always and the short one overrides it,
  // trading a little area for a single shared result path.
  always @*
  begin
    src_v = fpr_q[fpmc_idx(cur_level, source_reg_field)];
    dst_i = fpmc_idx(cur_level, dest_reg_field);
    is_rr = (op_code == `FPMC_OP_RR_S) || (op_code == `FPMC_OP_RR_D);
    is_cvs = (op_code == `FPMC_OP_CVS_S) || (op_code == `FPMC_OP_CVS_L);
    is_store = is_cvs || (op_code == `FPMC_OP_ST_S) || (op_code == `FPMC_OP_ST_D);
    cv = fpmc_toint(src_v, `FPMC_DIG_L);
    res_v = 64'h0;
    wr_reg = 1'b1;
    case (op_code)
      `FPMC_OP_LD_S: res_v = {load_data[63:32], 32'h0};
      `FPMC_OP_RR_S: res_v = {src_v[63:32], 32'h0};
      `FPMC_OP_LD_D: res_v = load_data;
      `FPMC_OP_RR_D: res_v = src_v;
      `FPMC_OP_CVL_S: res_v = fpmc_norm(
        load_data[63] ? {16'h0, 16'h0 - load_data[63:48]} : {16'h0, load_data[63:48]},
        load_data[63]);
      `FPMC_OP_CVL_L: res_v = fpmc_norm(
        load_data[63] ? (32'h0 - load_data[63:32]) : load_data[63:32],
        load_data[63]);
      `FPMC_OP_CVS_S:
      begin
        cv = fpmc_toint({src_v[63:32], 32'h0}, `FPMC_DIG_S);
        wr_reg = 1'b0;
      end
      `FPMC_OP_CVS_L:
      begin
        wr_reg = 1'b0;
      end
      default: wr_reg = 1'b0;
    endcase
    // Exception priority: option, address, protect, alignment
    if (!fp_option_present)
      exc_d = `FPMC_EXC_FUNC;
    else if (!is_rr && addr_out_of_range)
      exc_d = `FPMC_EXC_ADDR;
    else if (problem_state && area_unassigned)
      exc_d = `FPMC_EXC_PROT;
    else if (problem_state && is_store && area_read_only)
      exc_d = `FPMC_EXC_PROT;
    else if (!is_rr && storage_operand_address[0])
      exc_d = `FPMC_EXC_SPEC;
    else
      exc_d = `FPMC_EXC_NONE;
  end

  // ========================================================
  // Execute one request per enabled cycle; results settle next edge
  // Completion and exception outputs are one-cycle pulses; indicators
  // and store fields hold until a later accepted instruction moves them.
  // A low enable freezes every output, pulses included, so a stalled
  // sequencer still sees the last answer when it resumes.
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      store_valid <= 1'b0;
      store_addr <= 16'h0000;
      store_data <= 64'h0;
      store_size <= 2'h0;
      done <= 1'b0;
      ind_overflow <= 1'b0;
      ind_even <= 1'b0;
      ind_carry <= 1'b0;
      ind_negative <= 1'b0;
      ind_zero <= 1'b0;
      exc_code <= `FPMC_EXC_NONE;
      exc_suppress <= 1'b0;
    end
    else if (clk_en)
    begin
      done <= req_valid;
      store_valid <= 1'b0;
      exc_code <= `FPMC_EXC_NONE;
      exc_suppress <= 1'b0;
      if (req_valid)
      begin
        exc_code <= exc_d;
        exc_suppress <= (exc_d == `FPMC_EXC_FUNC) && is_rr;
        // Terminated work leaves storage and indicators untouched
        if (exc_d == `FPMC_EXC_NONE)
        begin
          ind_even <= 1'b0;
          ind_carry <= 1'b0;
          if (is_cvs)
          begin
            ind_overflow <= cv[33];
            ind_negative <= (op_code == `FPMC_OP_CVS_S) ? cv[15] : cv[31];
            ind_zero <= (op_code == `FPMC_OP_CVS_S) ? (cv[15:0] == 16'h0)
                                                    : (cv[31:0] == 32'h0);
          end
          else
          begin
            ind_overflow <= 1'b0;
            ind_negative <= is_store ? src_v[`FPMC_SIGN] : res_v[`FPMC_SIGN];
            ind_zero <= is_store ? (src_v == 64'h0) : (res_v == 64'h0);
          end
          if (is_store)
          begin
            store_valid <= 1'b1;
            store_addr <= storage_operand_address;
            case (op_code)
              `FPMC_OP_ST_S: store_data <= {src_v[63:32], 32'h0};
              `FPMC_OP_CVS_S: store_data <= {cv[15:0], 48'h0};
              `FPMC_OP_CVS_L: store_data <= {cv[31:0], 32'h0};
              default: store_data <= src_v;
            endcase
            store_size <= (op_code == `FPMC_OP_CVS_S) ? 2'h0 :
                          (op_code == `FPMC_OP_ST_D) ? 2'h2 : 2'h1;
          end
        end
      end
    end
  end

  // ========================================================
  // Register bank write; no reset so it maps to memory
  // Software must load a register before reading it after power-up.
  // The write uses the same exception decode as the output stage, so a
  // refused instruction can never leave a half-done register behind.
  always @(posedge core_clk)
  begin
    if (rst_n && clk_en && req_valid && wr_reg && exc_d == `FPMC_EXC_NONE)
      fpr_q[dst_i] <= res_v;
  end

endmodule // fpmc_unit
`default_nettype wire

// File: tb/fpmc_storage.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Main storage model, eight doublewords
module fpmc_storage (
  // Clock
  input wire logic core_clk,
  // Operand read
  input wire logic [15:0] addr,
  output logic [63:0] load_data,
  // Operand write
  input wire logic store_valid,
  input wire logic [15:0] store_addr,
  input wire logic [63:0] store_data,
  input wire logic [1:0] store_size
);
  logic [63:0] mem [0:7];
  // Loads only read, so a stray change shows later in the bench
  assign load_data = mem[addr[3:1]];
  // Merge by size; the untouched low part exposes an oversized write
  always @(posedge core_clk)
    if (store_valid)
      case (store_size)
        2'h0: mem[store_addr[3:1]][63:48] <= store_data[63:48];
        2'h1: mem[store_addr[3:1]][63:32] <= store_data[63:32];
        default: mem[store_addr[3:1]] <= store_data;
      endcase
endmodule // fpmc_storage
`default_nettype wire

// File: tb/fpmc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checker for the unit
module fpmc_monitor (
  // Clock and request
  input wire logic core_clk, rst_n, clk_en, req_valid,
  input wire logic [3:0] op_code,
  input wire logic [15:0] storage_operand_address,
  // Qualifiers
  input wire logic addr_out_of_range, problem_state, area_unassigned, area_read_only,
  input wire logic fp_option_present,
  // Answer
  input wire logic store_valid, done, exc_suppress,
  input wire logic ind_overflow, ind_even, ind_carry, ind_negative, ind_zero,
  input wire logic [2:0] exc_code
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Next edge must also be enabled, since a low enable freezes the answer
  wire go = req_valid && clk_en;
  wire rr = op_code == 4'h2 || op_code == 4'h5;
  wire wr = op_code inside {4'h1, 4'h4, 4'h7, 4'h9};
  wire ok = go && fp_option_present && !rr && !addr_out_of_range;
  wire [4:0] ind = {ind_overflow, ind_even, ind_carry, ind_negative, ind_zero};
  a_done_follows: assert property (go ##1 clk_en |-> done)
    else $error("done missing");
  a_func_trap: assert property (go && !fp_option_present ##1 clk_en |-> exc_code == 3'h4)
    else $error("no function trap");
  a_rr_suppress: assert property (go && !fp_option_present && rr ##1 clk_en |-> exc_suppress)
    else $error("no suppress");
  a_addr_check: assert property (go && fp_option_present && !rr && addr_out_of_range ##1 clk_en
    |-> exc_code == 3'h1)
    else $error("no address check");
  a_prot_unassigned: assert property (ok && problem_state && area_unassigned ##1 clk_en
    |-> exc_code == 3'h2)
    else $error("no protect check");
  a_prot_readonly: assert property (ok && problem_state && area_read_only && wr ##1 clk_en
    |-> exc_code == 3'h2)
    else $error("no read-only check");
  a_spec_check: assert property (ok && !problem_state && storage_operand_address[0] ##1 clk_en
    |-> exc_code == 3'h3)
    else $error("no spec check");
  a_exc_frozen: assert property (done && exc_code != 3'h0 |-> !store_valid && $stable(ind))
    else $error("refused op had effect");
  a_store_clean: assert property (store_valid |-> done && exc_code == 3'h0)
    else $error("stray store");
endmodule // fpmc_monitor
bind fpmc_unit fpmc_monitor i_mon (.core_clk, .rst_n, .clk_en, .req_valid, .op_code,
  .storage_operand_address, .addr_out_of_range, .problem_state, .area_unassigned,
  .area_read_only, .fp_option_present, .store_valid, .done, .exc_suppress, .ind_overflow,
  .ind_even, .ind_carry, .ind_negative, .ind_zero, .exc_code);
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Self-checking bench
module testbench;
  logic core_clk = 0, rst_n = 0, clk_en = 1, req_valid = 0, fp_option_present = 1;
  logic addr_out_of_range = 0, problem_state = 0, area_unassigned = 0, area_read_only = 0;
  logic [3:0] op_code = 0;
  logic [2:0] source_reg_field = 0, dest_reg_field = 0;
  logic [1:0] cur_level = 0;
  logic [15:0] storage_operand_address = 0;
  wire [63:0] load_data, store_data;
  wire [15:0] store_addr;
  wire [1:0] store_size;
  wire store_valid, done, ind_overflow, ind_even, ind_carry, ind_negative, ind_zero, exc_suppress;
  wire [2:0] exc_code;
  wire [4:0] ind = {ind_overflow, ind_even, ind_carry, ind_negative, ind_zero};
  int bad_count = 0, check_count = 0, cyc = 0;
  // Suppress flag stands one cycle only, so run captures it while it stands
  logic last_sup = 0;
  fpmc_unit i_dut (.core_clk, .rst_n, .clk_en, .req_valid, .op_code, .source_reg_field,
    .dest_reg_field, .cur_level, .storage_operand_address, .load_data, .addr_out_of_range,
    .problem_state, .area_unassigned, .area_read_only, .fp_option_present, .store_valid,
    .store_addr, .store_data, .store_size, .done, .ind_overflow, .ind_even, .ind_carry,
    .ind_negative, .ind_zero, .exc_code, .exc_suppress);
  fpmc_storage i_mem (.core_clk, .addr(storage_operand_address), .load_data, .store_valid,
    .store_addr, .store_data, .store_size);
  always #10 core_clk = ~core_clk;
  // Convert-store table: register value, stored word, indicators
  logic [63:0] tv [8] = '{64'h42100000_00000000, 64'h41180000_00000000, 64'h3f100000_00000000,
    64'h44800000_00000000, 64'hc4800000_00000000, 64'h48123456_789abcde,
    64'h48800000_00000000, 64'hc8800000_00000000};
  logic [31:0] tr [8] = '{32'h00100000, 32'h00010000, 32'h0, 32'h80000000, 32'h80000000,
    32'h12345678, 32'h80000000, 32'h80000000};
  logic [4:0] ti [8] = '{5'h00, 5'h00, 5'h01, 5'h10, 5'h02, 5'h00, 5'h10, 5'h02};
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Request lasts one edge; answer is read at the following falling edge
  task automatic run(input logic [3:0] op, input logic [2:0] s, input logic [2:0] d,
    input logic [15:0] a, input logic [2:0] e);
    op_code = op;
    source_reg_field = s;
    dest_reg_field = d;
    storage_operand_address = a;
    req_valid = 1;
    @(negedge core_clk);
    req_valid = 0;
    last_sup = exc_suppress;
    chk({60'h0, done, exc_code}, {60'h0, 1'b1, e});
    @(negedge core_clk);
  endtask
  // Register contents are seen only by storing them to the last word
  task automatic peek(input logic [2:0] r, input logic [63:0] exp);
    run(4'h4, r, 0, 16'he, 0);
    chk(i_mem.mem[7], exp);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_moves;
    i_mem.mem[1] = 64'hc1123456_789abcde;
    i_mem.mem[2] = 64'h41200000_11111111;
    i_mem.mem[3] = 64'h0_55555555;
    run(4'h3, 0, 1, 16'h2, 0);
    chk(ind, 5'h02);
    cur_level = 1;
    run(4'h0, 0, 1, 16'h4, 0);
    peek(1, 64'h41200000_00000000);
    cur_level = 0;
    peek(1, 64'hc1123456_789abcde);
    run(4'h2, 1, 2, 16'h0, 0);
    peek(2, 64'hc1123456_00000000);
    run(4'h5, 1, 3, 16'h0, 0);
    peek(3, 64'hc1123456_789abcde);
    run(4'h1, 1, 0, 16'h6, 0);
    chk(i_mem.mem[3], 64'hc1123456_55555555);
    chk(i_mem.mem[1], 64'hc1123456_789abcde);
    $display("t_moves finished");
  endtask
  task automatic t_convert;
    i_mem.mem[4] = 64'hfff0_0000_0000_0000;
    i_mem.mem[5] = 64'h00012345_00000000;
    run(4'h6, 0, 4, 16'h8, 0);
    chk(ind, 5'h02);
    peek(4, 64'hc2100000_00000000);
    run(4'h8, 0, 5, 16'ha, 0);
    peek(5, 64'h45123450_00000000);
    for (int i = 0; i < 8; i++)
    begin
      i_mem.mem[6] = tv[i];
      i_mem.mem[0] = 0;
      run(4'h3, 0, 6, 16'hc, 0);
      run(i < 5 ? 4'h7 : 4'h9, 6, 0, 16'h0, 0);
      chk(ti[i][4] ? ind[4:2] : ind, ti[i][4] ? ti[i][4:2] : ti[i]);
      chk(i_mem.mem[0], {tr[i], 32'h0});
      peek(6, tv[i]);
    end
    $display("t_convert finished");
  endtask
  task automatic t_checks;
    fp_option_present = 0;
    run(4'h0, 0, 2, 16'h4, 3'h4);
    chk(last_sup, 0);
    run(4'h2, 1, 2, 16'h0, 3'h4);
    chk(last_sup, 1);
    fp_option_present = 1;
    addr_out_of_range = 1;
    run(4'h3, 0, 2, 16'h2, 3'h1);
    addr_out_of_range = 0;
    problem_state = 1;
    area_unassigned = 1;
    run(4'h3, 0, 2, 16'h2, 3'h2);
    area_unassigned = 0;
    area_read_only = 1;
    run(4'h1, 1, 0, 16'h6, 3'h2);
    problem_state = 0;
    run(4'h3, 0, 2, 16'h3, 3'h3);
    peek(2, 64'hc1123456_00000000);
    chk(i_mem.mem[3], 64'hc1123456_55555555);
    problem_state = 1;
    run(4'h3, 0, 2, 16'h2, 0);
    $display("t_checks finished");
  endtask
  // Low enable must swallow a request and leave the bank untouched
  task automatic t_freeze;
    problem_state = 0;
    area_read_only = 0;
    clk_en = 0;
    op_code = 4'h3;
    dest_reg_field = 3;
    storage_operand_address = 16'h4;
    req_valid = 1;
    @(negedge core_clk);
    chk({done, store_valid}, 0);
    req_valid = 0;
    clk_en = 1;
    @(negedge core_clk);
    peek(3, 64'hc1123456_789abcde);
    $display("t_freeze finished");
  endtask
  // Hang guard, far above the hundred or so cycles the run needs
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      bad_count++;
      complete_run;
    end
  end
  initial
  begin
    repeat (4) @(negedge core_clk);
    rst_n = 1;
    chk({done, store_valid, exc_code, ind}, 0);
    t_moves;
    t_convert;
    t_checks;
    t_freeze;
    complete_run;
  end
endmodule // testbench
`default_nettype wire
